// file: common/cstx_pkg.sv
// What this block does
// - Two-bit length code picks 2^10, 2^12, 2^14 or 2^15 calibration bits.
// - Pass mode clear: pass when any enabled receive port has valid video.
// - Pass mode set: pass only when all enabled receive ports have valid video.
// - Invert bit set sends the pattern starting with one instead.
// - Single sequence waits for the next idle period on the output.
// - Single bit clears itself once its sequence has been fully sent.
// - Periodic enable sends a sequence after each Frame End; off sends none.
// - Status bit 4 reports which transmit port is selected for readback.
// - Synchronized status is one while input streams are synchronized.
// - Synchronized status is forced to zero when synchronized forwarding is off.
// - Asynchronous forwarding: pass only while valid video is being delivered.
// - Asynchronous forwarding: an interrupting error clears pass.
// - Synchronized forwarding: pass when valid data is available for output.
// - Register accesses go to the port chosen by the port-select register.
// - A write reaches every transmit port whose write-enable bit is set.
package cstx_pkg;

  localparam int CSTX_PORTS = 2;
  localparam int CSTX_LANES = 4;
  localparam int CSTX_RX_PORTS = 4;
  localparam int CSTX_CNT_W = 16;

  // Register offsets
  localparam logic [7:0] ADDR_PORT_SEL = 8'h32;
  localparam logic [7:0] ADDR_CTL2 = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h35;

  // Reset values
  localparam logic [7:0] RST_PORT_SEL = 8'h00;
  localparam logic [7:0] RST_CTL2 = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // Port-select fields
  localparam int SEL_READ_BIT = 4;
  localparam int SEL_WE1_BIT = 1;
  localparam int SEL_WE0_BIT = 0;

  // Calibration and pass control fields
  localparam int CTL2_LEN_HI = 5;
  localparam int CTL2_LEN_LO = 4;
  localparam int CTL2_PASS_MODE_BIT = 3;
  localparam int CTL2_INVERT_BIT = 2;
  localparam int CTL2_SINGLE_BIT = 1;
  localparam int CTL2_PERIODIC_BIT = 0;

  // Status fields
  localparam int STS_PORT_NUM_BIT = 4;
  localparam int STS_SYNC_BIT = 1;
  localparam int STS_PASS_BIT = 0;

  // Calibration length exponents per code
  localparam int CAL_EXP_00 = 10;
  localparam int CAL_EXP_01 = 12;
  localparam int CAL_EXP_10 = 14;
  localparam int CAL_EXP_11 = 15;

  typedef struct packed {
    logic [1:0] length;
    logic invert;
    logic periodic;
  } cstx_cal_cfg_s;

  typedef struct packed {
    logic [CSTX_RX_PORTS-1:0] rx_enabled;
    logic [CSTX_RX_PORTS-1:0] rx_valid;
    logic delivering;
    logic tx_error;
    logic sync_fwd_en;
    logic streams_synced;
  } cstx_rx_status_s;

  typedef struct packed {
    logic frame_end;
    logic idle;
  } cstx_link_evt_s;

  typedef enum logic {CAL_IDLE, CAL_SEND} cstx_cal_state_e;

  // Last count of a sequence, one less than its length in bits
  function automatic logic [CSTX_CNT_W-1:0] cstx_cal_last(input logic [1:0] code);
    int e;
    e = CAL_EXP_00;
    unique case (code)
      2'h0: e = CAL_EXP_00;
      2'h1: e = CAL_EXP_01;
      2'h2: e = CAL_EXP_10;
      2'h3: e = CAL_EXP_11;
    endcase
    return CSTX_CNT_W'((32'h1 << e) - 32'h1);
  endfunction

endpackage

// file: tb/csi_tx_skew_cal_and_status_tb_top.sv
`timescale 1ns/1ps
module csi_tx_skew_cal_and_status_tb_top import cstx_pkg::*; ;
  typedef struct packed {
    logic mode;
    cstx_rx_status_s st;
    logic pass;
    logic sync;
  } cstx_row_s;

  // Mode, enabled, valid, {delivering, error, sync fwd, synced}, {pass, sync}
  localparam cstx_row_s ROWS [13] = '{
    {1'h0, 4'h1, 4'h1, 4'h8, 2'h2}, {1'h0, 4'h3, 4'h4, 4'h8, 2'h0},
    {1'h0, 4'hF, 4'h2, 4'h8, 2'h2}, {1'h1, 4'h5, 4'h4, 4'h8, 2'h0},
    {1'h1, 4'h5, 4'h7, 4'h8, 2'h2}, {1'h0, 4'h1, 4'h1, 4'hC, 2'h0},
    {1'h0, 4'h1, 4'h1, 4'h0, 2'h0}, {1'h0, 4'h1, 4'h1, 4'h3, 2'h3},
    {1'h0, 4'h1, 4'h1, 4'h2, 2'h2}, {1'h0, 4'h0, 4'h0, 4'h1, 2'h0},
    {1'h1, 4'h0, 4'hF, 4'h2, 2'h0}, {1'h1, 4'h5, 4'h7, 4'h8, 2'h2},
    {1'h1, 4'h5, 4'h4, 4'h3, 2'h1}};
  localparam int LENS [4] = '{1024, 4096, 16384, 32768};

  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  cstx_rx_status_s rx_status [CSTX_PORTS];
  cstx_link_evt_s link_evt [CSTX_PORTS];
  logic [CSTX_PORTS-1:0] tx_pass;
  logic [CSTX_PORTS-1:0] tx_sync;
  logic [CSTX_PORTS-1:0] cal_active;
  logic [CSTX_LANES-1:0] cal_lanes [CSTX_PORTS];
  int err_total = 0;
  int n_tests = 0;

  always #25 core_clk = ~core_clk;
  always #15 link_clk = ~link_clk;

  cstx_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_status(rx_status), .link_evt(link_evt), .tx_pass(tx_pass), .tx_sync(tx_sync),
    .cal_active(cal_active), .cal_lanes(cal_lanes));
  cstx_rx_model rx (.link_clk(link_clk), .rst_n(rst_n), .cal_active(cal_active),
    .cal_lanes(cal_lanes), .link_evt(link_evt));

  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // Request with the output busy, then open an idle period on both ports
  task automatic run_cal(input logic [7:0] ctl, input int len, input logic [3:0] first);
    int s [CSTX_PORTS];
    for (int p = 0; p < CSTX_PORTS; p++) s[p] = rx.seq_cnt[p];
    wr(ADDR_CTL2, ctl);
    wait_core(20);
    chk_cnt(rx.seq_cnt[0] + rx.seq_cnt[1], s[0] + s[1]);
    rx.set_idle(2'h3);
    for (int i = 0; i < 40000 && rx.seq_cnt[1] == s[1]; i++) @(posedge core_clk);
    wait_core(30);
    for (int p = 0; p < CSTX_PORTS; p++) begin
      chk_cnt(rx.seq_cnt[p], s[p] + 1);
      chk_cnt(rx.last_len[p], len);
      chk_reg({4'h0, rx.first_lanes[p]}, {4'h0, first});
      chk_cnt(rx.bad_bits[p], 0);
    end
    rd(ADDR_CTL2, d);
    chk_reg(d, ctl & 8'hFD);
    rx.set_idle(2'h0);
  endtask

  initial begin
    #3000000;
    err_total++;
    finish_test();
  end

  initial begin
    int p;
    int s0;
    for (int q = 0; q < CSTX_PORTS; q++) rx_status[q] = '0;
    wait_core(8);
    rst_n = 1'b1;
    wait_core(4);
    chk_reg({tx_sync, tx_pass}, 4'h0);
    rd(ADDR_CTL2, d);
    chk_reg(d, RST_CTL2);
    rd(ADDR_STATUS, d);
    chk_reg(d, RST_STATUS);
    for (int i = 0; i < 13; i++) begin
      p = i % 2;
      wr(ADDR_PORT_SEL, (p == 1) ? 8'h13 : 8'h03);
      wr(ADDR_CTL2, {4'h0, ROWS[i].mode, 3'h0});
      @(posedge core_clk);
      #2;
      rx_status[p] = ROWS[i].st;
      wait_core(2);
      chk_reg({6'h00, tx_sync[p], tx_pass[p]}, {6'h00, ROWS[i].sync, ROWS[i].pass});
      rd(ADDR_STATUS, d);
      chk_reg(d, {3'h0, p[0], 2'h0, ROWS[i].sync, ROWS[i].pass});
      rx_status[p] = '0;
    end
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_CTL2, 8'h38);
    wr(ADDR_PORT_SEL, 8'h10);
    wr(ADDR_CTL2, 8'h24);
    rd(ADDR_CTL2, d);
    chk_reg(d, 8'h08);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, d);
    chk_reg(d, 8'h10);
    rd(8'h40, d);
    chk_reg(d, 8'h00);
    wr(ADDR_PORT_SEL, 8'h00);
    rd(ADDR_CTL2, d);
    chk_reg(d, 8'h38);
    wr(ADDR_PORT_SEL, 8'h03);
    wr(ADDR_CTL2, 8'h28);
    wr(ADDR_PORT_SEL, 8'h13);
    rd(ADDR_CTL2, d);
    chk_reg(d, 8'h28);
    wr(ADDR_PORT_SEL, 8'h03);
    wr(ADDR_CTL2, 8'h00);
    wait_core(6);
    for (int c = 0; c < 4; c++) run_cal({2'h0, c[1:0], 4'h2}, LENS[c], 4'h0);
    run_cal(8'h06, LENS[0], 4'hF);
    wr(ADDR_CTL2, 8'h01);
    wait_core(6);
    rx.set_idle(2'h3);
    s0 = rx.seq_cnt[0];
    rx.frame_end(0);
    wait_core(1500);
    chk_cnt(rx.seq_cnt[0], s0 + 1);
    chk_cnt(rx.last_len[0], LENS[0]);
    chk_cnt(rx.seq_cnt[1], s0);
    wr(ADDR_CTL2, 8'h00);
    wait_core(6);
    rx.frame_end(0);
    wait_core(1500);
    chk_cnt(rx.seq_cnt[0], s0 + 1);
    finish_test();
  end
endmodule // csi_tx_skew_cal_and_status_tb_top

// file: tb/cstx_rx_model.sv
`timescale 1ns/1ps
module cstx_rx_model import cstx_pkg::*; (
  // Link side
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic [CSTX_PORTS-1:0] cal_active,
  input wire logic [CSTX_LANES-1:0] cal_lanes [CSTX_PORTS],
  // Output state seen by the transmitter
  output cstx_link_evt_s link_evt [CSTX_PORTS]
);
  int run_len [CSTX_PORTS];
  int last_len [CSTX_PORTS];
  int seq_cnt [CSTX_PORTS];
  int bad_bits [CSTX_PORTS];
  logic [CSTX_LANES-1:0] first_lanes [CSTX_PORTS];
  logic [CSTX_LANES-1:0] prev_lanes [CSTX_PORTS];

  initial begin
    for (int p = 0; p < CSTX_PORTS; p++) begin
      link_evt[p] = '0;
      run_len[p] = 0;
      last_len[p] = 0;
      seq_cnt[p] = 0;
      bad_bits[p] = 0;
    end
  end

  // Output stays busy until the bench reports an idle period
  task automatic set_idle(input logic [CSTX_PORTS-1:0] v);
    @(posedge link_clk);
    #1;
    for (int p = 0; p < CSTX_PORTS; p++) link_evt[p].idle = v[p];
  endtask

  task automatic frame_end(input int p);
    @(posedge link_clk);
    #1;
    link_evt[p].frame_end = 1'b1;
    @(posedge link_clk);
    #1;
    link_evt[p].frame_end = 1'b0;
  endtask

  // Each sequence must alternate on all lanes alike and be quiet outside
  always @(posedge link_clk) begin
    for (int p = 0; p < CSTX_PORTS; p++) begin
      if (rst_n !== 1'b1) begin
        run_len[p] = 0;
      end else if (cal_active[p] === 1'b1) begin
        if (run_len[p] == 0) first_lanes[p] = cal_lanes[p];
        else if (cal_lanes[p] !== ~prev_lanes[p]) bad_bits[p]++;
        if (cal_lanes[p] !== {CSTX_LANES{cal_lanes[p][0]}}) bad_bits[p]++;
        prev_lanes[p] = cal_lanes[p];
        run_len[p]++;
      end else begin
        if (cal_lanes[p] !== '0) bad_bits[p]++;
        if (run_len[p] != 0) begin
          last_len[p] = run_len[p];
          seq_cnt[p]++;
        end
        run_len[p] = 0;
      end
    end
  end
endmodule // cstx_rx_model

// file: verilog/cstx_ctrl.sv
`timescale 1ns/1ps
module cstx_ctrl import cstx_pkg::*; (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Receive-side status per transmit port
  input cstx_rx_status_s rx_status [CSTX_PORTS],
  // Link events per transmit port
  input cstx_link_evt_s link_evt [CSTX_PORTS],
  // Status indications
  output logic [CSTX_PORTS-1:0] tx_pass,
  output logic [CSTX_PORTS-1:0] tx_sync,
  // Calibration outputs on the link clock
  output logic [CSTX_PORTS-1:0] cal_active,
  output logic [CSTX_LANES-1:0] cal_lanes [CSTX_PORTS]
);

  logic read_port_q;
  logic [CSTX_PORTS-1:0] write_en_q;
  logic [1:0] len_q [CSTX_PORTS];
  logic [CSTX_PORTS-1:0] pass_mode_q;
  logic [CSTX_PORTS-1:0] invert_q;
  logic [CSTX_PORTS-1:0] single_q;
  logic [CSTX_PORTS-1:0] periodic_q;
  logic [CSTX_PORTS-1:0] req_tgl_q;
  logic [CSTX_PORTS-1:0] done_tgl;
  logic [2:0] done_s_q [CSTX_PORTS];
  logic [CSTX_PORTS-1:0] done_evt;
  logic [CSTX_PORTS-1:0] ctl2_wr;
  logic [CSTX_PORTS-1:0] single_start;
  logic sel_wr;

  // True when enabled receive ports qualify for pass under the given mode
  function automatic logic pass_base(input cstx_rx_status_s s, input logic all_mode);
    logic any_ok;
    logic all_ok;
    any_ok = |(s.rx_enabled & s.rx_valid);
    all_ok = (s.rx_enabled != '0) && ((s.rx_enabled & ~s.rx_valid) == '0);
    return all_mode ? all_ok : any_ok;
  endfunction

  function automatic logic [7:0] ctl2_word(input logic p);
    logic [7:0] w;
    w = RST_CTL2;
    w[CTL2_LEN_HI:CTL2_LEN_LO] = len_q[p];
    w[CTL2_PASS_MODE_BIT] = pass_mode_q[p];
    w[CTL2_INVERT_BIT] = invert_q[p];
    w[CTL2_SINGLE_BIT] = single_q[p];
    w[CTL2_PERIODIC_BIT] = periodic_q[p];
    return w;
  endfunction

  function automatic logic [7:0] status_word(input logic p);
    logic [7:0] w;
    w = RST_STATUS;
    w[STS_PORT_NUM_BIT] = read_port_q;
    w[STS_SYNC_BIT] = tx_sync[p];
    w[STS_PASS_BIT] = tx_pass[p];
    return w;
  endfunction

  assign sel_wr = reg_wr && (reg_addr == ADDR_PORT_SEL);

  always_comb begin
    for (int p = 0; p < CSTX_PORTS; p++) begin
      ctl2_wr[p] = reg_wr && (reg_addr == ADDR_CTL2) && write_en_q[p];
      single_start[p] = ctl2_wr[p] && reg_wdata[CTL2_SINGLE_BIT] && (!single_q[p] || done_evt[p]);
      done_evt[p] = done_s_q[p][1] ^ done_s_q[p][2];
    end
  end

  // Port selection for readback and write enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      read_port_q <= RST_PORT_SEL[SEL_READ_BIT];
      write_en_q <= RST_PORT_SEL[SEL_WE1_BIT:SEL_WE0_BIT];
    end else if (sel_wr) begin
      read_port_q <= reg_wdata[SEL_READ_BIT];
      write_en_q <= reg_wdata[SEL_WE1_BIT:SEL_WE0_BIT];
    end
  end

  // Configuration fields, written in every enabled port at once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        len_q[p] <= RST_CTL2[CTL2_LEN_HI:CTL2_LEN_LO];
      end
      pass_mode_q <= '0;
      invert_q <= '0;
      periodic_q <= '0;
    end else begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        if (ctl2_wr[p]) begin
          len_q[p] <= reg_wdata[CTL2_LEN_HI:CTL2_LEN_LO];
          pass_mode_q[p] <= reg_wdata[CTL2_PASS_MODE_BIT];
          invert_q[p] <= reg_wdata[CTL2_INVERT_BIT];
          periodic_q[p] <= reg_wdata[CTL2_PERIODIC_BIT];
        end
      end
    end
  end

  // Single request flag; a new request wins over the self-clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      single_q <= '0;
      req_tgl_q <= '0;
    end else begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        single_q[p] <= single_start[p] || (single_q[p] && !done_evt[p]);
        req_tgl_q[p] <= req_tgl_q[p] ^ single_start[p];
      end
    end
  end

  // Completion toggles from the link domain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        done_s_q[p] <= '0;
      end
    end else begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        done_s_q[p] <= {done_s_q[p][1:0], done_tgl[p]};
      end
    end
  end

  // Pass and synchronized indications
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_pass <= '0;
      tx_sync <= '0;
    end else begin
      for (int p = 0; p < CSTX_PORTS; p++) begin
        if (rx_status[p].sync_fwd_en) begin
          tx_pass[p] <= pass_base(rx_status[p], pass_mode_q[p]);
        end else begin
          tx_pass[p] <= pass_base(rx_status[p], pass_mode_q[p])
            && rx_status[p].delivering && !rx_status[p].tx_error;
        end
        tx_sync[p] <= rx_status[p].sync_fwd_en && rx_status[p].streams_synced;
      end
    end
  end

  // Readback through the selected port; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PORT_SEL: begin
          reg_rdata <= {3'h0, read_port_q, 2'h0, write_en_q};
        end
        ADDR_CTL2: begin
          reg_rdata <= ctl2_word(read_port_q);
        end
        ADDR_STATUS: begin
          reg_rdata <= status_word(read_port_q);
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  for (genvar g = 0; g < CSTX_PORTS; g++) begin : g_cal
    cstx_skew_cal u_cal (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .cfg('{length: len_q[g], invert: invert_q[g], periodic: periodic_q[g]}),
      .req_tgl(req_tgl_q[g]),
      .evt(link_evt[g]),
      .cal_active(cal_active[g]),
      .cal_lanes(cal_lanes[g]),
      .done_tgl(done_tgl[g])
    );
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_pass_any: assert property (rx_status[0].sync_fwd_en && !pass_mode_q[0]
    |=> tx_pass[0] == |($past(rx_status[0].rx_enabled) & $past(rx_status[0].rx_valid)))
    else $error("any-port pass wrong");
  a_pass_all: assert property (pass_mode_q[0] && rx_status[0].sync_fwd_en
    && ((rx_status[0].rx_enabled & ~rx_status[0].rx_valid) != '0) |=> !tx_pass[0])
    else $error("all-port pass asserted with a port missing");
  a_async_err: assert property (!rx_status[1].sync_fwd_en && rx_status[1].tx_error |=> !tx_pass[1])
    else $error("pass held through an error");
  a_async_deliv: assert property (!rx_status[0].sync_fwd_en && !rx_status[0].delivering
    |=> !tx_pass[0])
    else $error("pass without delivery");
  a_sync_off: assert property (!rx_status[1].sync_fwd_en |=> !tx_sync[1])
    else $error("sync status while sync forwarding off");
  a_sync_on: assert property (rx_status[0].sync_fwd_en && rx_status[0].streams_synced
    |=> tx_sync[0])
    else $error("sync status missing");
  a_port_num: assert property (reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata[STS_PORT_NUM_BIT] == $past(read_port_q))
    else $error("port number readback wrong");
  a_write_both: assert property (reg_wr && reg_addr == ADDR_CTL2 && write_en_q == 2'h3
    |=> invert_q[0] == invert_q[1] && periodic_q[0] == periodic_q[1])
    else $error("dual write did not reach both ports");
  a_write_gate: assert property (reg_wr && reg_addr == ADDR_CTL2 && !write_en_q[1]
    |=> $stable(len_q[1]) && $stable(pass_mode_q[1]))
    else $error("write reached a disabled port");
  a_self_clear: assert property (done_evt[0] && !single_start[0] |=> !single_q[0])
    else $error("single bit not cleared");
  a_single_req: assert property (single_start[1] |=> single_q[1] && req_tgl_q[1] != $past(req_tgl_q[1]))
    else $error("single request not issued");
  c_dual_write: cover property (reg_wr && reg_addr == ADDR_CTL2 && write_en_q == 2'h3);
  c_single_done: cover property (single_q[0] ##1 done_evt[0]);
  c_pass_all: cover property (pass_mode_q[1] && tx_pass[1]);

endmodule // cstx_ctrl

// file: verilog/cstx_skew_cal.sv
`timescale 1ns/1ps
module cstx_skew_cal import cstx_pkg::*; (
  // Clocks and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Core-domain controls
  input cstx_cal_cfg_s cfg,
  input wire logic req_tgl,
  // Link-domain events
  input cstx_link_evt_s evt,
  // Link-domain outputs
  output logic cal_active,
  output logic [CSTX_LANES-1:0] cal_lanes,
  output logic done_tgl
);

  logic [1:0] lrst_q;
  logic lrst_n;
  cstx_cal_cfg_s cfg_s1_q;
  cstx_cal_cfg_s cfg_q;
  logic [2:0] req_s_q;
  logic req_evt;
  cstx_cal_state_e state_q;
  logic [CSTX_CNT_W-1:0] cnt_q;
  logic pend_single_q;
  logic pend_per_q;
  logic is_single_q;
  logic start;
  logic last;

  // Reset release and controls cross into the link domain
  always_ff @(posedge link_clk) begin
    lrst_q <= {lrst_q[0], rst_n};
  end
  assign lrst_n = lrst_q[1];

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      cfg_s1_q <= '0;
      cfg_q <= '0;
      req_s_q <= '0;
    end else begin
      cfg_s1_q <= cfg;
      cfg_q <= cfg_s1_q;
      req_s_q <= {req_s_q[1:0], req_tgl};
    end
  end
  assign req_evt = req_s_q[1] ^ req_s_q[2];

  assign start = (state_q == CAL_IDLE) && evt.idle && (pend_single_q || pend_per_q);
  assign last = (state_q == CAL_SEND) && (cnt_q == '0);

  // Pending requests; a new request beats the clear of its start
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      pend_single_q <= 1'b0;
      pend_per_q <= 1'b0;
    end else begin
      pend_single_q <= req_evt || (pend_single_q && !start);
      pend_per_q <= cfg_q.periodic && (evt.frame_end || (pend_per_q && !start));
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      state_q <= CAL_IDLE;
      cnt_q <= '0;
      is_single_q <= 1'b0;
      cal_active <= 1'b0;
      cal_lanes <= '0;
      done_tgl <= 1'b0;
    end else begin
      unique case (state_q)
        CAL_IDLE: begin
          if (start) begin
            state_q <= CAL_SEND;
            cnt_q <= cstx_cal_last(cfg_q.length);
            is_single_q <= pend_single_q;
            cal_active <= 1'b1;
            cal_lanes <= {CSTX_LANES{cfg_q.invert}};
          end
        end
        CAL_SEND: begin
          cnt_q <= cnt_q - CSTX_CNT_W'(1);
          cal_lanes <= ~cal_lanes;
          if (last) begin
            state_q <= CAL_IDLE;
            cal_active <= 1'b0;
            cal_lanes <= '0;
            done_tgl <= done_tgl ^ is_single_q;
          end
        end
      endcase
    end
  end

  default clocking @(posedge link_clk); endclocking
  default disable iff (!lrst_n);

  a_first_bit: assert property (start |=> cal_active && (cal_lanes == {CSTX_LANES{$past(cfg_q.invert)}}))
    else $error("first calibration bit wrong");
  a_bits_alternate: assert property (cal_active && $past(cal_active) |-> cal_lanes == ~$past(cal_lanes))
    else $error("calibration bits do not alternate");
  a_start_idle: assert property ($rose(cal_active) |-> $past(evt.idle))
    else $error("calibration started outside idle");
  a_short_len: assert property (start && cfg_q.length == 2'h0 |=> cal_active [*8] ##1 (cnt_q == 16'h03F7))
    else $error("calibration length wrong");
  a_no_periodic: assert property (!cfg_q.periodic |=> !pend_per_q)
    else $error("periodic pending while disabled");
  c_single_done: cover property (last && is_single_q);
  c_periodic_run: cover property (start && pend_per_q && !pend_single_q);

endmodule // cstx_skew_cal
